// ==== lpwc_pkg.sv ====
package lpwc_pkg;

  // ------------------------------------------------------------
  // Register map (byte offsets on the plain register port)
  // ------------------------------------------------------------
  localparam logic [3:0] LPWC_OFS_MODE   = 4'h0;
  localparam logic [3:0] LPWC_OFS_STATUS = 4'h1;
  localparam logic [3:0] LPWC_OFS_WAKE_A = 4'h2;
  localparam logic [3:0] LPWC_OFS_WAKE_X = 4'h3;
  localparam logic [3:0] LPWC_OFS_WAKE_F = 4'h4;
  localparam logic [3:0] LPWC_OFS_PWR    = 4'h5;

  // Mode register fields
  localparam int LPWC_MODE_IDLE_SEL   = 0;
  localparam int LPWC_MODE_SYSCLK_ON  = 1;
  localparam int LPWC_MODE_FAST_WAKE  = 2;
  localparam int LPWC_MODE_CLK_LOW    = 3;
  localparam int LPWC_MODE_HI_XTAL    = 4;
  localparam int LPWC_MODE_SUB_XTAL   = 5;

  // Power register fields
  localparam int LPWC_PWR_WDT_EN      = 0;
  localparam int LPWC_PWR_LVD_EN      = 1;

  // Status register fields
  localparam int LPWC_ST_PDF          = 0;
  localparam int LPWC_ST_TO           = 1;
  localparam int LPWC_ST_HI_STABLE    = 2;
  localparam int LPWC_ST_LO_STABLE    = 3;

  // Reset values
  localparam logic [7:0] LPWC_MODE_RST = 8'h00;
  localparam logic [7:0] LPWC_WAKE_RST = 8'h00;
  localparam logic [7:0] LPWC_PWR_RST  = 8'h01;

  // Start-up stabilise counts, in oscillator cycles
  localparam logic [10:0] LPWC_SST_HI_CYCLES = 11'h400;
  localparam logic [10:0] LPWC_SST_LO_CYCLES = 11'h400;

  // Pin and interrupt widths
  localparam int LPWC_PORT_W = 8;
  localparam int LPWC_PINS_W = 3 * LPWC_PORT_W;
  localparam int LPWC_IRQ_W  = 8;

  typedef enum logic [2:0] {
    LPWC_RUN,
    LPWC_IDLE_SYSCLK_OFF,
    LPWC_IDLE_SYSCLK_ON,
    LPWC_DEEP_SLEEP,
    LPWC_LIGHT_SLEEP,
    LPWC_WAKE_WAIT
  } lpwc_state_type;

  typedef enum logic [1:0] {
    LPWC_CAUSE_PIN,
    LPWC_CAUSE_IRQ,
    LPWC_CAUSE_WDT
  } lpwc_cause_type;

endpackage : lpwc_pkg

// ==== lpwc_sst_if.sv ====
`timescale 1ns/100ps
interface lpwc_sst_if;
  logic start;
  logic need_lo;
  logic hi_done;
  logic lo_done;

  modport ctrl (output start, output need_lo,
                input hi_done, input lo_done);
  modport cnt  (input start, input need_lo,
                output hi_done, output lo_done);
endinterface : lpwc_sst_if

// ==== lpwc_startup_counter.sv ====
`timescale 1ns/100ps
module lpwc_startup_counter
  import lpwc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  lpwc_sst_if.cnt   sst
);

  typedef enum logic [1:0] {
    LPWC_SST_IDLE,
    LPWC_SST_HI,
    LPWC_SST_LO
  } lpwc_sst_type;

  lpwc_sst_type state_r;
  logic [10:0]  count_r;
  logic         hi_done_r;
  logic         lo_done_r;
  logic         last;

  assign last        = (count_r == 11'h001);
  assign sst.hi_done = hi_done_r;
  assign sst.lo_done = lo_done_r;

  // ------------------------------------------------------------
  // One counter, high crystal first, low crystal afterwards
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r   <= LPWC_SST_IDLE;
      count_r   <= 11'h000;
      hi_done_r <= 1'b1;
      lo_done_r <= 1'b1;
    end else begin
      unique case (state_r)
        LPWC_SST_IDLE: begin
          if (sst.start) begin
            state_r   <= LPWC_SST_HI;
            count_r   <= LPWC_SST_HI_CYCLES;
            hi_done_r <= 1'b0;
            lo_done_r <= !sst.need_lo;
          end
        end
        LPWC_SST_HI: begin
          count_r <= count_r - 11'h001;
          if (last) begin
            hi_done_r <= 1'b1;
            // Low crystal waits its turn on the shared counter
            if (!lo_done_r) begin
              state_r <= LPWC_SST_LO;
              count_r <= LPWC_SST_LO_CYCLES;
            end else begin
              state_r <= LPWC_SST_IDLE;
            end
          end
        end
        LPWC_SST_LO: begin
          count_r <= count_r - 11'h001;
          if (last) begin
            lo_done_r <= 1'b1;
            state_r   <= LPWC_SST_IDLE;
          end
        end
      endcase
    end
  end

endmodule : lpwc_startup_counter

// ==== lpwc_ctrl.sv ====
`timescale 1ns/100ps
module lpwc_ctrl
  import lpwc_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic [3:0]             addr_i,
  input  wire logic [7:0]             wr_data_i,
  input  wire logic                   wr_stb_i,
  input  wire logic                   rd_stb_i,
  output logic      [7:0]             rd_data_o,
  input  wire logic                   halt_i,
  input  wire logic                   clr_wdt_i,
  input  wire logic                   ext_reset_i,
  input  wire logic                   wdt_overflow_i,
  input  wire logic [LPWC_PINS_W-1:0] pin_in_i,
  input  wire logic [LPWC_PINS_W-1:0] pin_out_i,
  output logic      [LPWC_PINS_W-1:0] pin_out_o,
  input  wire logic [LPWC_IRQ_W-1:0]  irq_flag_i,
  input  wire logic [LPWC_IRQ_W-1:0]  irq_en_i,
  input  wire logic                   stack_full_i,
  output logic                        cpu_hold_o,
  output logic                        sysclk_en_o,
  output logic                        tbc_en_o,
  output logic                        sub_en_o,
  output logic                        wdt_run_o,
  output logic                        wdt_clear_o,
  output logic                        full_reset_o,
  output logic                        wdt_reset_o,
  output logic                        pc_sp_reset_o,
  output logic                        irq_take_o,
  output logic                        resume_o,
  output logic                        run_on_sub_o,
  output logic                        sysclk_low_o,
  output logic                        periph_clk_low_o
);

  localparam int EV_W = LPWC_PINS_W + LPWC_IRQ_W;

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  lpwc_state_type             state_r, state_nxt;
  lpwc_cause_type             cause_r;
  lpwc_sst_if                 sst ();
  logic [7:0]                 mode_r;
  logic [7:0]                 pwr_r;
  logic [LPWC_PINS_W-1:0]     wake_en_r;
  logic                       pdf_r;
  logic                       to_r;
  logic [7:0]                 rd_data_r;
  logic [EV_W-1:0]            sync1_r;
  logic [EV_W-1:0]            sync2_r;
  logic [EV_W-1:0]            prev_r;
  logic [LPWC_IRQ_W-1:0]      irq_armed_r;
  logic [LPWC_IRQ_W-1:0]      irq_hit_r;
  logic [LPWC_PINS_W-1:0]     pin_hold_r;
  logic                       sst_start_r;
  logic                       need_lo_r;
  logic                       fast_r;
  logic                       wdt_clear_r;
  logic                       full_reset_r;
  logic                       wdt_reset_r;
  logic                       pc_sp_reset_r;
  logic                       irq_take_r;
  logic                       resume_r;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  logic                   wr_mode, wr_pwr;
  logic [2:0]             wr_wake;
  logic                   low_power, wdt_en, lvd_en;
  logic [LPWC_PINS_W-1:0] pin_fall;
  logic [LPWC_IRQ_W-1:0]  irq_rise;
  logic                   pin_wake, irq_wake, wdt_wake, any_wake;
  logic                   need_sst, halt_take, hi_ok;

  assign wr_mode = wr_stb_i && (addr_i == LPWC_OFS_MODE);
  assign wr_pwr  = wr_stb_i && (addr_i == LPWC_OFS_PWR);
  assign wr_wake[0] = wr_stb_i && (addr_i == LPWC_OFS_WAKE_A);
  assign wr_wake[1] = wr_stb_i && (addr_i == LPWC_OFS_WAKE_X);
  assign wr_wake[2] = wr_stb_i && (addr_i == LPWC_OFS_WAKE_F);

  assign wdt_en    = pwr_r[LPWC_PWR_WDT_EN];
  assign lvd_en    = pwr_r[LPWC_PWR_LVD_EN];
  assign low_power = (state_r != LPWC_RUN) && (state_r != LPWC_WAKE_WAIT);
  assign halt_take = halt_i && (state_r == LPWC_RUN);
  assign hi_ok     = sst.hi_done && !sst_start_r;

  // Edges are taken from the second stage and its delayed copy prev_r
  assign pin_fall = prev_r[LPWC_PINS_W-1:0]
                    & ~sync2_r[LPWC_PINS_W-1:0];
  assign irq_rise = sync2_r[EV_W-1:LPWC_PINS_W] & irq_armed_r;

  // A flag high at entry is not armed, so it cannot wake
  assign irq_wake = |irq_rise;
  assign pin_wake = |(pin_fall & wake_en_r);
  assign wdt_wake = wdt_overflow_i;
  assign any_wake = low_power &&
                    (pin_wake || irq_wake || wdt_wake);

  // Deep sleep always counts; light sleep and clock-off idle only on a cold high crystal
  assign need_sst = (state_r == LPWC_DEEP_SLEEP) ||
                    (((state_r == LPWC_LIGHT_SLEEP) ||
                      (state_r == LPWC_IDLE_SYSCLK_OFF)) &&
                     mode_r[LPWC_MODE_HI_XTAL]);

  // ------------------------------------------------------------
  // Halt dispatch and wake sequencing
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LPWC_RUN: begin
        if (halt_i) begin
          if (mode_r[LPWC_MODE_IDLE_SEL]) begin
            state_nxt = mode_r[LPWC_MODE_SYSCLK_ON]
                        ? LPWC_IDLE_SYSCLK_ON
                        : LPWC_IDLE_SYSCLK_OFF;
          end else if (wdt_en || lvd_en) begin
            state_nxt = LPWC_LIGHT_SLEEP;
          end else begin
            state_nxt = LPWC_DEEP_SLEEP;
          end
        end
      end
      LPWC_IDLE_SYSCLK_OFF, LPWC_IDLE_SYSCLK_ON,
      LPWC_DEEP_SLEEP, LPWC_LIGHT_SLEEP: begin
        if (any_wake) begin
          state_nxt = (need_sst && !wdt_wake) ? LPWC_WAKE_WAIT : LPWC_RUN;
        end
      end
      LPWC_WAKE_WAIT: begin
        // First instruction waits for the stable high oscillator unless fast wake runs on the sub clock
        if (hi_ok || fast_r) begin
          state_nxt = LPWC_RUN;
        end
      end
    endcase
    if (ext_reset_i) begin
      state_nxt = LPWC_RUN;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= LPWC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Wake cause, start-up request and fast wake marker
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cause_r     <= LPWC_CAUSE_PIN;
      irq_hit_r   <= '0;
      sst_start_r <= 1'b0;
      need_lo_r   <= 1'b0;
      fast_r      <= 1'b0;
    end else begin
      sst_start_r <= 1'b0;
      if (any_wake) begin
        cause_r   <= wdt_wake ? LPWC_CAUSE_WDT :
                     irq_wake ? LPWC_CAUSE_IRQ : LPWC_CAUSE_PIN;
        irq_hit_r   <= irq_rise;
        sst_start_r <= need_sst && !wdt_wake;
        need_lo_r   <= (state_r == LPWC_DEEP_SLEEP)
                       && mode_r[LPWC_MODE_SUB_XTAL];
        // Light sleep fast wake runs from the sub clock meanwhile
        fast_r      <= (state_r == LPWC_LIGHT_SLEEP)
                       && mode_r[LPWC_MODE_HI_XTAL]
                       && mode_r[LPWC_MODE_FAST_WAKE];
      end else if (hi_ok) begin
        fast_r <= 1'b0;
      end
    end
  end

  assign sst.start   = sst_start_r;
  assign sst.need_lo = need_lo_r;

  lpwc_startup_counter u_sst (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .sst     (sst.cnt)
  );

  // ------------------------------------------------------------
  // Wake event synchroniser and interrupt arming
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_r <= '1;
      sync2_r <= '1;
      prev_r  <= '1;
    end else begin
      sync1_r <= {irq_flag_i, pin_in_i};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Arm only the interrupts whose flag is low when the halt lands
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_armed_r <= '0;
    end else if (halt_take) begin
      irq_armed_r <= ~sync2_r[EV_W-1:LPWC_PINS_W];
    end else if (!low_power) begin
      irq_armed_r <= '0;
    end
  end

  // ------------------------------------------------------------
  // Software registers; halt leaves all but the status flags untouched
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_r    <= LPWC_MODE_RST;
      pwr_r     <= LPWC_PWR_RST;
    end else begin
      if (wr_mode) begin
        mode_r <= wr_data_i;
      end
      if (wr_pwr) begin
        pwr_r <= wr_data_i;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_wake
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          wake_en_r[g*LPWC_PORT_W +: LPWC_PORT_W] <= LPWC_WAKE_RST;
        end else if (wr_wake[g]) begin
          wake_en_r[g*LPWC_PORT_W +: LPWC_PORT_W] <= wr_data_i;
        end
      end
    end
  endgenerate

  // Status flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pdf_r <= 1'b0;
      to_r  <= 1'b0;
    end else begin
      if (halt_take) begin
        pdf_r <= 1'b1;
      end else if (clr_wdt_i) begin
        pdf_r <= 1'b0;
      end
      if (wdt_overflow_i) begin
        to_r <= 1'b1;
      end else if (halt_take) begin
        to_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Read port, data stands one cycle after the strobe
  // ------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    unique case (addr_i)
      LPWC_OFS_MODE:   rd_mux = mode_r;
      LPWC_OFS_STATUS: rd_mux = {4'h0, sst.lo_done, hi_ok, to_r, pdf_r};
      LPWC_OFS_WAKE_A: rd_mux = wake_en_r[7:0];
      LPWC_OFS_WAKE_X: rd_mux = wake_en_r[15:8];
      LPWC_OFS_WAKE_F: rd_mux = wake_en_r[23:16];
      LPWC_OFS_PWR:    rd_mux = pwr_r;
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_stb_i ? rd_mux : 8'h00;
    end
  end

  assign rd_data_o = rd_data_r;

  // ------------------------------------------------------------
  // Pin hold and wake result pulses
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_hold_r <= '0;
    end else if (state_r == LPWC_RUN && !halt_i) begin
      pin_hold_r <= pin_out_i;
    end
  end

  logic finish;
  assign finish = (state_r != LPWC_RUN) && (state_nxt == LPWC_RUN)
                  && !ext_reset_i;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdt_clear_r   <= 1'b0;
      full_reset_r  <= 1'b0;
      wdt_reset_r   <= 1'b0;
      pc_sp_reset_r <= 1'b0;
      irq_take_r    <= 1'b0;
      resume_r      <= 1'b0;
    end else begin
      wdt_clear_r   <= halt_take || clr_wdt_i;
      full_reset_r  <= ext_reset_i;
      // Awake, an overflow is a full watchdog reset
      wdt_reset_r   <= wdt_overflow_i && !low_power;
      pc_sp_reset_r <= finish && (cause_r == LPWC_CAUSE_WDT
                       || wdt_wake);
      irq_take_r    <= finish && !wdt_wake
                       && (any_wake ? irq_wake : cause_r == LPWC_CAUSE_IRQ)
                       && |((any_wake ? irq_rise : irq_hit_r) & irq_en_i)
                       && !stack_full_i;
      resume_r      <= finish && !wdt_wake
                       && !(cause_r == LPWC_CAUSE_WDT && !any_wake)
                       && !((any_wake ? irq_wake
                             : cause_r == LPWC_CAUSE_IRQ)
                            && |((any_wake ? irq_rise : irq_hit_r)
                                 & irq_en_i)
                            && !stack_full_i);
    end
  end

  // ------------------------------------------------------------
  // Clock enables and outputs
  // ------------------------------------------------------------
  assign cpu_hold_o    = (state_r != LPWC_RUN) || halt_i;
  assign sysclk_en_o   = (state_r == LPWC_RUN)
                         || (state_r == LPWC_IDLE_SYSCLK_ON)
                         || (state_r == LPWC_WAKE_WAIT && hi_ok);
  assign tbc_en_o      = (state_r == LPWC_RUN) || (state_r == LPWC_WAKE_WAIT)
                         || (state_r == LPWC_IDLE_SYSCLK_OFF)
                         || (state_r == LPWC_IDLE_SYSCLK_ON);
  // Sub clock feeds the watchdog, so it runs with its enable and also for LVD, fast wake and idle
  assign sub_en_o      = wdt_en || lvd_en || fast_r
                         || (state_r == LPWC_IDLE_SYSCLK_OFF)
                         || (state_r == LPWC_IDLE_SYSCLK_ON);
  assign wdt_run_o     = wdt_en && (state_r != LPWC_DEEP_SLEEP);
  assign wdt_clear_o   = wdt_clear_r;
  assign full_reset_o  = full_reset_r;
  assign wdt_reset_o   = wdt_reset_r;
  assign pc_sp_reset_o = pc_sp_reset_r;
  assign irq_take_o    = irq_take_r;
  assign resume_o      = resume_r;
  assign run_on_sub_o  = fast_r;
  assign sysclk_low_o  = mode_r[LPWC_MODE_CLK_LOW] || fast_r;
  assign periph_clk_low_o = sysclk_low_o;
  // Outside run the pins show the held copy, registers untouched
  assign pin_out_o     = pin_hold_r;

endmodule : lpwc_ctrl

// ==== lpwc_ctrl_monitor.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Halt and wake port checks
// ----------------------------------------
module lpwc_ctrl_monitor
  import lpwc_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   reset_i,
  input wire logic                   halt_i,
  input wire logic                   ext_reset_i,
  input wire logic                   wdt_overflow_i,
  input wire logic                   rd_stb_i,
  input wire logic [7:0]             rd_data_o,
  input wire logic                   cpu_hold_o,
  input wire logic                   wdt_clear_o,
  input wire logic                   full_reset_o,
  input wire logic                   wdt_reset_o,
  input wire logic                   pc_sp_reset_o,
  input wire logic                   resume_o,
  input wire logic [LPWC_PINS_W-1:0] pin_out_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Halt counts only when the core ran last cycle
  sequence s_halt;
    halt_i && !$past(cpu_hold_o);
  endsequence
  sequence s_held3;
    cpu_hold_o [*3];
  endsequence
  property p_hold; s_halt |=> cpu_hold_o; endproperty
  property p_wdt_clr; s_halt |=> wdt_clear_o; endproperty
  property p_pins; s_held3 |-> $stable(pin_out_o); endproperty
  property p_ext; $rose(ext_reset_i) |-> ##[1:2] full_reset_o; endproperty
  property p_wdt_wake; cpu_hold_o && wdt_overflow_i |=> pc_sp_reset_o;
  endproperty
  property p_wdt_run; !cpu_hold_o && wdt_overflow_i |-> ##[1:2] wdt_reset_o;
  endproperty
  property p_rd_idle; !$past(rd_stb_i) |-> rd_data_o == 8'h00; endproperty
  // Resume only just after leaving the held state
  property p_resume;
    resume_o |-> !cpu_hold_o && ($past(cpu_hold_o) || $past(cpu_hold_o, 2));
  endproperty
  a_hold: assert property (p_hold) else $error("no hold");
  a_wdt_clr: assert property (p_wdt_clr) else $error("no clear");
  a_pins: assert property (p_pins) else $error("pins moved");
  a_ext: assert property (p_ext) else $error("no full reset");
  a_wdt_wake: assert property (p_wdt_wake) else $error("no pc");
  a_wdt_run: assert property (p_wdt_run) else $error("no wdt");
  a_rd_idle: assert property (p_rd_idle) else $error("stray data");
  a_resume: assert property (p_resume) else $error("bad resume");
endmodule : lpwc_ctrl_monitor
bind lpwc_ctrl lpwc_ctrl_monitor i_mon (.*);

// ==== lpwc_cpu_model.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Core model issuing halt
// ----------------------------------------
module lpwc_cpu_model (
  input  wire logic clk_i,
  input  wire logic cpu_hold_i,
  input  wire logic halt_req_i,
  output logic      halt_o
);
  // A held core executes nothing, so no halt then
  always_ff @(posedge clk_i) begin
    halt_o <= halt_req_i && !cpu_hold_i && !halt_o;
  end
endmodule : lpwc_cpu_model

// ==== tb_lpwc_ctrl.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Bench
// ----------------------------------------
module tb_lpwc_ctrl
  import lpwc_pkg::*;
;
  logic clk_i = 1'b0, reset_i = 1'b1, wr_stb_i = 1'b0, rd_stb_i = 1'b0;
  logic clr_wdt_i = 1'b0, ext_reset_i = 1'b0, wdt_overflow_i = 1'b0;
  logic stack_full_i = 1'b0, halt_req = 1'b0, halt_i;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wr_data_i = 8'h00, irq_flag_i = 8'h00, irq_en_i = 8'h00;
  logic [7:0] rd_data_o, d, clks;
  logic [LPWC_PINS_W-1:0] pin_in_i = '1, pin_out_i = 24'h5A5A5A, pin_out_o;
  logic cpu_hold_o, sysclk_en_o, tbc_en_o, sub_en_o, wdt_run_o, wdt_clear_o;
  logic full_reset_o, wdt_reset_o, pc_sp_reset_o, irq_take_o, resume_o;
  logic run_on_sub_o, sysclk_low_o, periph_clk_low_o;
  int mismatches = 0, compares = 0, n;
  // Clock gates packed for one compare
  assign clks = {4'h0, sysclk_en_o, tbc_en_o, sub_en_o, wdt_run_o};
  lpwc_ctrl i_dut (.*);
  lpwc_cpu_model i_cpu (.clk_i(clk_i), .cpu_hold_i(cpu_hold_o),
                        .halt_req_i(halt_req), .halt_o(halt_i));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  // Settle one step past the edge so flags are stable
  task tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : tick
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_stb_i <= 1'b1;
    @(posedge clk_i);
    wr_stb_i <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_stb_i <= 1'b1;
    @(posedge clk_i);
    rd_stb_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask : rd
  task hlt;
    @(posedge clk_i);
    halt_req <= 1'b1;
    @(posedge clk_i);
    halt_req <= 1'b0;
    tick(4);
  endtask : hlt
  // Bounded wait for either wake pulse
  task ww(output int k);
    k = 0;
    while (k < 1200 && resume_o !== 1'b1 && irq_take_o !== 1'b1) begin
      tick(1);
      k++;
    end
    if (k >= 1200) begin
      mismatches++;
      $display("[FAIL] %0t wake timeout", $time);
      tally_and_finish();
    end
  endtask : ww
  task t_regs;
    rd(LPWC_OFS_PWR);
    chk(d, LPWC_PWR_RST);
    rd(LPWC_OFS_STATUS);
    chk(d & 8'h03, 8'h00);
    wr(LPWC_OFS_WAKE_X, 8'hA5);
    rd(LPWC_OFS_WAKE_X);
    chk(d, 8'hA5);
    rd(4'hF);
    chk(d, 8'h00);
    wr(LPWC_OFS_MODE, 8'h08);
    tick(1);
    chk({6'h0, sysclk_low_o, periph_clk_low_o}, 8'h03);
    $display("t_regs done");
  endtask : t_regs
  task t_idle_off;
    wr(LPWC_OFS_WAKE_A, 8'h01);
    wr(LPWC_OFS_MODE, 8'h01);
    hlt;
    chk(clks, 8'h07);
    rd(LPWC_OFS_STATUS);
    chk(d & 8'h03, 8'h01);
    pin_out_i <= 24'hA5A5A5;
    tick(3);
    chk(pin_out_o[7:0], 8'h5A);
    pin_in_i <= 24'hFFFFFE;
    ww(n);
    chk({6'h0, irq_take_o, resume_o}, 8'h01);
    pin_in_i <= '1;
    $display("t_idle_off done");
  endtask : t_idle_off
  task t_irq;
    wr(LPWC_OFS_MODE, 8'h03);
    irq_en_i <= 8'h06;
    irq_flag_i <= 8'h02;
    hlt;
    chk(clks, 8'h0F);
    tick(10);
    chk({7'h0, cpu_hold_o}, 8'h01);
    stack_full_i <= 1'b1;
    irq_flag_i <= 8'h06;
    ww(n);
    chk({6'h0, irq_take_o, resume_o}, 8'h01);
    irq_flag_i <= 8'h00;
    stack_full_i <= 1'b0;
    hlt;
    irq_flag_i <= 8'h04;
    ww(n);
    chk({6'h0, irq_take_o, resume_o}, 8'h02);
    irq_flag_i <= 8'h00;
    $display("t_irq done");
  endtask : t_irq
  task t_deep;
    wr(LPWC_OFS_PWR, 8'h00);
    wr(LPWC_OFS_MODE, 8'h10);
    hlt;
    chk(clks, 8'h00);
    pin_in_i <= 24'hFFFFFE;
    ww(n);
    chk({7'h0, n >= 1024}, 8'h01);
    rd(LPWC_OFS_STATUS);
    chk(d & 8'h04, 8'h04);
    pin_in_i <= '1;
    wr(LPWC_OFS_PWR, 8'h01);
    $display("t_deep done");
  endtask : t_deep
  // Fast wake runs on the sub clock until the high crystal settles
  task t_fast;
    wr(LPWC_OFS_MODE, 8'h14);
    hlt;
    pin_in_i <= 24'hFFFFFE;
    ww(n);
    chk({6'h0, run_on_sub_o, sysclk_low_o}, 8'h03);
    pin_in_i <= '1;
    tick(1100);
    chk({7'h0, run_on_sub_o}, 8'h00);
    $display("t_fast done");
  endtask : t_fast
  task t_light;
    wr(LPWC_OFS_MODE, 8'h00);
    hlt;
    chk(clks, 8'h03);
    wdt_overflow_i <= 1'b1;
    tick(1);
    wdt_overflow_i <= 1'b0;
    tick(4);
    rd(LPWC_OFS_STATUS);
    chk(d & 8'h03, 8'h03);
    clr_wdt_i <= 1'b1;
    tick(1);
    clr_wdt_i <= 1'b0;
    rd(LPWC_OFS_STATUS);
    chk(d & 8'h01, 8'h00);
    wdt_overflow_i <= 1'b1;
    tick(1);
    wdt_overflow_i <= 1'b0;
    wr(LPWC_OFS_MODE, 8'h01);
    hlt;
    ext_reset_i <= 1'b1;
    tick(1);
    ext_reset_i <= 1'b0;
    tick(4);
    chk({7'h0, cpu_hold_o}, 8'h00);
    $display("t_light done");
  endtask : t_light
  initial begin
    tick(16);
    reset_i <= 1'b0;
    tick(2);
    t_regs;
    t_idle_off;
    t_irq;
    t_deep;
    t_fast;
    t_light;
    tally_and_finish;
  end
endmodule : tb_lpwc_ctrl
